// ---- rtl/acp_pkg.sv ----
// acp_pkg: constants, types and register map for the converter serial-output block
// assumes a 100 MHz system clock and an AXI4-Lite register port with 32-bit data
package acp_pkg;

    localparam int          RESULT_BITS   = 16;
    localparam int          CNT_W         = 5;
    localparam int          CONV_CYCLES   = 40;
    localparam logic [5:0]  CONV_CYCLES_W = 6'h28;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_RESULT    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h14;
    localparam logic [7:0]  OFS_SAMPLE    = 8'h18;

    // ctrl field positions
    localparam int          CTRL_EXT_CLK  = 0;
    localparam int          CTRL_PDOWN    = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h1;

    // interrupt bit positions
    localparam int          IRQ_DONE      = 0;
    localparam int          IRQ_WORD_OUT  = 1;
    localparam int          IRQ_W         = 2;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        ACP_IDLE,
        ACP_CONVERT,
        ACP_SHIFT,
        ACP_CASCADE
    } acp_state_e;

    // serial link pins as seen by the device
    typedef struct packed {
        logic read_convert_n;
        logic serial_data_clock;
        logic cascade_in;
    } acp_link_in_s;

    typedef struct packed {
        logic serial_data;
        logic busy_n;
    } acp_link_out_s;

endpackage

// ---- rtl/acp_sync_edge.sv ----
// acp_sync_edge: two-flop synchroniser per pin with rising/falling edge pulses
// assumes pins are asynchronous to aclk; edges are detected after the second flop
`timescale 1ns/1ps
module acp_sync_edge #(
    parameter int N = 3
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [N-1:0] pin,
    output logic      [N-1:0] level,
    output logic      [N-1:0] rise,
    output logic      [N-1:0] fall
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;

    // first flop feeds only the second one
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else if (ce)
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule

// ---- rtl/acp_core.sv ----
// acp_core: serial result shifter with cascade pass-through and power-down hold
// assumes an external host drives convert pulses and a normally low data clock
// Operation
// - the cascade input reaches the serial output only in external data clock mode.
// - simultaneous sampling in a chain yields one null bit between 16-bit words.
// - a high power-down pin shuts down the analog and reference circuits; here it only blocks new conversions.
// - during power-down the last result stays readable unless already shifted out.
`timescale 1ns/1ps
module acp_core (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    input  wire acp_pkg::acp_link_in_s link_in,
    input  wire logic                  power_down_pin,
    input  wire logic                  clock_source_select,
    output acp_pkg::acp_link_out_s     link_out,
    output logic                       irq,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    // pin synchronisation: [2]=convert_n [1]=data clock [0]=cascade, [3]/[4] pins
    logic [4:0] pin_lvl;
    logic [4:0] pin_rise;
    logic [4:0] pin_fall;

    acp_sync_edge #(.N(5)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     ({clock_source_select, power_down_pin, link_in}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // state
    acp_pkg::acp_state_e                  state_q;
    logic [acp_pkg::RESULT_BITS-1:0]      shift_q;
    logic [acp_pkg::RESULT_BITS-1:0]      result_q;
    logic [acp_pkg::RESULT_BITS-1:0]      sample_q;
    logic [acp_pkg::CNT_W-1:0]            bits_q;
    logic [5:0]                           conv_cnt_q;
    logic                                 sdo_q;
    logic [1:0]                           ctrl_q;
    logic [acp_pkg::IRQ_W-1:0]            irq_stat_q;
    logic [acp_pkg::IRQ_W-1:0]            irq_en_q;
    logic [acp_pkg::IRQ_W-1:0]            irq_set;
    logic [acp_pkg::IRQ_W-1:0]            irq_clr;

    // pin and control decode; a pin or a control bit can each select a mode
    wire ext_mode  = pin_lvl[4] | ctrl_q[acp_pkg::CTRL_EXT_CLK];
    wire pdown     = pin_lvl[3] | ctrl_q[acp_pkg::CTRL_PDOWN];
    wire conv_go   = pin_fall[2]; // sync flops reset low, so no false fall follows reset
    wire dclk_rise = pin_rise[1];
    wire casc_lvl  = pin_lvl[0];

    wire conv_done = (state_q == acp_pkg::ACP_CONVERT) &&
                     (conv_cnt_q == acp_pkg::CONV_CYCLES_W);
    wire word_end  = (state_q == acp_pkg::ACP_SHIFT) && dclk_rise &&
                     (bits_q == acp_pkg::CNT_W'(acp_pkg::RESULT_BITS - 1));

    // conversion and shift sequencer; power-down blocks new conversions only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q    <= acp_pkg::ACP_IDLE;
            conv_cnt_q <= '0;
            bits_q     <= '0;
            shift_q    <= '0;
            result_q   <= '0;
        end
        else if (ce)
        begin
            unique case (state_q)
                acp_pkg::ACP_IDLE, acp_pkg::ACP_CASCADE:
                begin
                    if (conv_go && !pdown)
                    begin
                        state_q    <= acp_pkg::ACP_CONVERT;
                        conv_cnt_q <= '0;
                    end
                    else if (state_q == acp_pkg::ACP_IDLE && dclk_rise && bits_q == '0)
                    begin
                        // the first clock already moves on to the second bit
                        state_q <= acp_pkg::ACP_SHIFT; // held result still readable
                        shift_q <= {shift_q[acp_pkg::RESULT_BITS-2:0], 1'b0};
                        bits_q  <= 5'h01;
                    end
                end
                acp_pkg::ACP_CONVERT:
                begin
                    conv_cnt_q <= conv_cnt_q + 6'h01;
                    if (conv_done)
                    begin
                        result_q <= sample_q;
                        shift_q  <= sample_q;
                        bits_q   <= '0;
                        state_q  <= acp_pkg::ACP_IDLE;
                    end
                end
                acp_pkg::ACP_SHIFT:
                begin
                    if (dclk_rise)
                    begin
                        shift_q <= {shift_q[acp_pkg::RESULT_BITS-2:0], 1'b0}; // msb first
                        bits_q  <= bits_q + 5'h01;
                        if (word_end)
                            state_q <= ext_mode ? acp_pkg::ACP_CASCADE
                                                : acp_pkg::ACP_IDLE;
                    end
                end
            endcase
        end
    end

    // output bit: own word, then cascade bits one per data clock; the cascade
    // bit is sampled a clock late, which is what yields the null bit in a chain
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sdo_q <= 1'b0;
        else if (ce)
        begin
            if (state_q == acp_pkg::ACP_CASCADE && dclk_rise)
                sdo_q <= ext_mode ? casc_lvl : 1'b0;
            else if (state_q == acp_pkg::ACP_SHIFT || state_q == acp_pkg::ACP_IDLE)
                sdo_q <= shift_q[acp_pkg::RESULT_BITS-1];
            else if (state_q == acp_pkg::ACP_CONVERT)
                sdo_q <= 1'b0;
        end
    end

    assign link_out.serial_data = sdo_q;
    assign link_out.busy_n      = (state_q != acp_pkg::ACP_CONVERT);

    // ---------------- axi4-lite slave ----------------
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // write decode on the captured address and strobes
    logic        wdata_q_strb0;
    logic [3:0]  wstrb_q;
    wire wr_fire  = aw_got_q && w_got_q && !bvalid_q;
    wire wr_ctrl  = wr_fire && awaddr_q == acp_pkg::OFS_CTRL && wdata_q_strb0;
    wire wr_clr   = wr_fire && awaddr_q == acp_pkg::OFS_IRQ_CLR && wdata_q_strb0;
    wire wr_en    = wr_fire && awaddr_q == acp_pkg::OFS_IRQ_EN && wdata_q_strb0;
    wire wr_samp  = wr_fire && awaddr_q == acp_pkg::OFS_SAMPLE;
    wire wr_map   = wr_ctrl | wr_clr | wr_en | wr_samp | (awaddr_q == acp_pkg::OFS_STATUS) |
                    (awaddr_q == acp_pkg::OFS_RESULT) | (awaddr_q == acp_pkg::OFS_IRQ_STAT);
    assign wdata_q_strb0 = wstrb_q[0];

    // write channel capture, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= acp_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_map ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // software registers; hardware set wins over software clear
    assign irq_set = {word_end, conv_done};
    assign irq_clr = wr_clr ? wdata_q[acp_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q     <= acp_pkg::CTRL_RESET;
            irq_en_q   <= '0;
            irq_stat_q <= '0;
            sample_q   <= '0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl_q <= wdata_q[1:0];
            if (wr_en)
                irq_en_q <= wdata_q[acp_pkg::IRQ_W-1:0];
            if (wr_samp)
                sample_q <= wdata_q[acp_pkg::RESULT_BITS-1:0];
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // read channel, one cycle after address acceptance
    wire [31:0] rd_mux =
        (s_axi_araddr == acp_pkg::OFS_CTRL)     ? {30'h0, ctrl_q} :
        (s_axi_araddr == acp_pkg::OFS_STATUS)   ? {27'h0, pdown, ext_mode, bits_q == '0,
                                                   state_q == acp_pkg::ACP_CASCADE,
                                                   state_q == acp_pkg::ACP_CONVERT} :
        (s_axi_araddr == acp_pkg::OFS_RESULT)   ? {16'h0, result_q} :
        (s_axi_araddr == acp_pkg::OFS_IRQ_STAT) ? {30'h0, irq_stat_q} :
        (s_axi_araddr == acp_pkg::OFS_IRQ_EN)   ? {30'h0, irq_en_q} :
        (s_axi_araddr == acp_pkg::OFS_SAMPLE)   ? {16'h0, sample_q} : 32'h0;
    wire rd_map = (s_axi_araddr <= acp_pkg::OFS_SAMPLE) && (s_axi_araddr[1:0] == 2'h0) &&
                  (s_axi_araddr != acp_pkg::OFS_IRQ_CLR);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= acp_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_map ? rd_mux : 32'h0;
                rresp_q  <= rd_map ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end
endmodule

// ---- tb/acp_core_assertions.sv ----
// acp_core_assertions: port checks on busy timing, serial output and register port
// assumes it is bound into acp_core and that pins change slower than its edge finder
`timescale 1ns/1ps
module acp_core_assertions (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire acp_pkg::acp_link_in_s  link_in,
    input wire logic                   power_down_pin,
    input wire logic                   clock_source_select,
    input wire acp_pkg::acp_link_out_s link_out,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready
);
    localparam int BUSY_LOW = acp_pkg::CONV_CYCLES + 1;
    logic [2:0] dclk_q;
    logic [6:0] low_q;
    logic [4:0] rise_q;
    wire        dclk_rise = dclk_q[1] & ~dclk_q[2];
    wire        rise_inc  = dclk_rise && (rise_q != 5'h1f);

    // busy length and data clocks since completion; the data clock count saturates at 31, the busy count wraps
    always_ff @(posedge aclk)
    begin
        dclk_q <= {dclk_q[1:0], link_in.serial_data_clock};
        low_q  <= (!aresetn || link_out.busy_n) ? 7'h00 : low_q + 7'h01;
        rise_q <= (!aresetn || !link_out.busy_n) ? 5'h00 : rise_q + {4'h0, rise_inc};
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // conversion window length and power-down blocking
    a_busy_length: assert property ($rose(link_out.busy_n) |-> low_q == BUSY_LOW)
        else $error("busy low time is wrong");
    a_pd_blocks: assert property (
        power_down_pin [*5] ##0 link_out.busy_n |=> link_out.busy_n)
        else $error("conversion started in power down");
    // after the own word: cascade level in external mode, zero in internal mode
    a_casc_follow: assert property (
        clock_source_select && rise_q >= 5'd17 && $changed(link_out.serial_data)
        |-> link_out.serial_data == link_in.cascade_in)
        else $error("cascade bit not forwarded");
    a_int_no_casc: assert property (
        !clock_source_select && rise_q >= 5'd18 |-> !link_out.serial_data)
        else $error("cascade leaked in internal mode");
    // register port handshakes
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    c_done: cover property ($rose(link_out.busy_n));
    c_casc: cover property (rise_q == 5'd20);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == acp_pkg::RESP_SLVERR);
endmodule

bind acp_core acp_core_assertions i_chk (
    .aclk, .aresetn, .link_in, .power_down_pin, .clock_source_select, .link_out,
    .s_axi_rdata, .s_axi_rresp, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready
);

// ---- tb/acp_host.sv ----
// acp_host: behavioural host that pulses convert and clocks the result out
// assumes tasks are called just after an aclk edge so its own edges never meet aclk
`timescale 1ns/1ps
module acp_host (
    output acp_pkg::acp_link_in_s link_in,
    input  wire logic             busy_n,
    input  wire logic             serial_data
);
    // link idles with convert high, data clock low and cascade at a fixed level
    initial link_in = '{1'b1, 1'b0, 1'b0};

    // convert pulse, then note whether the busy window opened and wait for it to close
    task automatic convert(output logic started);
        int i;
        #3 link_in.read_convert_n = 1'b0; // one shared convert line, not delayed
        #100 link_in.read_convert_n = 1'b1;
        started = !busy_n;
        for (i = 0; i < 200 && !busy_n; i++) #10; // no data clocks while busy
    endtask

    // read after completion only; the clock runs within the frame and stops after
    task automatic read_bits(input int n, input logic [31:0] casc, output logic [31:0] b);
        b = 32'h0;
        for (int k = 0; k < n; k++)
        begin
            link_in.cascade_in = casc[k];
            #65 b[k] = serial_data;
            link_in.serial_data_clock = 1'b1;
            #60 link_in.serial_data_clock = 1'b0;
        end
        link_in.cascade_in = 1'b0;
    endtask
endmodule

// ---- tb/adc_cascade_serial_powerdown_tb.sv ----
// adc_cascade_serial_powerdown_tb: registers, conversion, cascade and power-down runs
// assumes acp_core, its checker and the acp_host model are compiled before it
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module adc_cascade_serial_powerdown_tb;
    logic                   aclk, aresetn, ce, power_down_pin, clock_source_select, irq, ok;
    acp_pkg::acp_link_in_s  link_in;
    acp_pkg::acp_link_out_s link_out;
    logic [7:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata, rd, bits;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp, rsp;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                   s_axi_rvalid, s_axi_rready;
    int                     mismatches, total_checks;

    acp_core i_dut (.aclk, .aresetn, .ce, .link_in, .power_down_pin, .clock_source_select,
        .link_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    acp_host i_host (.link_in, .busy_n(link_out.busy_n), .serial_data(link_out.serial_data));

    // free-running system clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic test_done();
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            if (s_axi_awready === 1'b1) aw_d = 1'b1;
            if (s_axi_wready === 1'b1) w_d = 1'b1;
            @(posedge aclk);
            if (aw_d) s_axi_awvalid <= 1'b0;
            if (w_d) s_axi_wvalid <= 1'b0;
        end while (!(aw_d && w_d));
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    // read: ready raised late on purpose so the held answer is exercised
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic chk_word(input logic [15:0] w);
        for (int k = 0; k < 16; k++) `CHK(bits[k], w[15-k])
    endtask

    // reset values, unmapped place and interrupt enable
    task automatic t_regs();
        rdr(acp_pkg::OFS_CTRL);
        `CHK(rd[1:0], acp_pkg::CTRL_RESET)
        rdr(8'h40);
        `CHK({rd, rsp}, {32'h0, acp_pkg::RESP_SLVERR})
        wr(8'h40, 32'h1);
        `CHK(rsp, acp_pkg::RESP_SLVERR)
        wr(acp_pkg::OFS_IRQ_EN, 32'h3);
        rdr(acp_pkg::OFS_IRQ_EN);
        `CHK({rd[1:0], rsp}, {2'h3, acp_pkg::RESP_OKAY})
        // clock enable low: a whole convert pulse goes unseen
        ce <= 1'b0;
        i_host.convert(ok);
        @(posedge aclk);
        ce <= 1'b1;
        `CHK(ok, 1'b0)
    endtask

    // external mode: own word msb first, then the cascade level per clock
    task automatic t_ext();
        clock_source_select <= 1'b1;
        wr(acp_pkg::OFS_SAMPLE, 32'ha5c3);
        i_host.convert(ok);
        rdr(acp_pkg::OFS_IRQ_STAT);
        `CHK({ok, rd[0], irq}, 3'b111)
        i_host.read_bits(20, 32'h0005_5555, bits);
        chk_word(16'ha5c3);
        `CHK(bits[19:17], 3'b101) // bit 16 is the null bit, skipped
        rdr(acp_pkg::OFS_IRQ_STAT);
        `CHK(rd[1:0], 2'h3)
        wr(acp_pkg::OFS_IRQ_CLR, 32'h3);
        rdr(acp_pkg::OFS_IRQ_STAT);
        `CHK({rd[1:0], irq}, 3'b000)
    endtask

    // internal mode with interrupts masked: cascade ones never reach the output
    task automatic t_int();
        clock_source_select <= 1'b0; // internal clock mode
        wr(acp_pkg::OFS_CTRL, 32'h0);
        wr(acp_pkg::OFS_IRQ_EN, 32'h0);
        wr(acp_pkg::OFS_SAMPLE, 32'h3c96);
        i_host.convert(ok);
        rdr(acp_pkg::OFS_IRQ_STAT);
        `CHK({ok, rd[0], irq}, 3'b110)
        i_host.read_bits(20, 32'hffff_ffff, bits);
        chk_word(16'h3c96);
        `CHK(bits[19:17], 3'b000)
        wr(acp_pkg::OFS_IRQ_EN, 32'h3);
        `CHK(irq, 1'b1)
        wr(acp_pkg::OFS_IRQ_CLR, 32'h3);
        `CHK(irq, 1'b0)
    endtask

    // power down: convert refused, last result still shifts out
    task automatic t_pd();
        clock_source_select <= 1'b1;
        wr(acp_pkg::OFS_CTRL, 32'h1);
        wr(acp_pkg::OFS_SAMPLE, 32'h5a0f);
        i_host.convert(ok);
        wr(acp_pkg::OFS_SAMPLE, 32'hffff);
        power_down_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        i_host.convert(ok);
        rdr(acp_pkg::OFS_STATUS);
        `CHK({ok, rd[4]}, 2'b01)
        i_host.read_bits(16, 32'h0, bits);
        chk_word(16'h5a0f);
        rdr(acp_pkg::OFS_RESULT);
        `CHK(rd[15:0], 16'h5a0f)
        @(posedge aclk);
        power_down_pin <= 1'b0; // no conversion is relied on after release
    endtask

    // reset for four cycles, then the scenarios in order
    initial
    begin
        {aresetn, power_down_pin, clock_source_select, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, mismatches, total_checks} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_ext();
        t_int();
        t_pd();
        test_done();
    end

    // the whole run needs about ten microseconds
    initial
    begin
        #200us;
        mismatches++;
        test_done();
    end
endmodule
